// ==== design/docs_selector.sv ====
// drive output condition selector with wishbone register file
// What this block does
// RULE1 - code 2: level window within half bandwidth
// RULE2 - code 3: hysteresis level detect on frequency
// RULE3 - code 4: inverse of code 3 detect
// RULE4 - level, bandwidth clamp 0..400Hz, below maximum
// RULE5 - code 8: overvoltage trip asserts output
// RULE6 - code 9: undervoltage trip asserts output
// RULE7 - code 10: heatsink overheat asserts output
// RULE8 - code 11: analog or serial command lost
// RULE9 - code 12: running with nonzero output voltage
// RULE10 - code 13: stopped, no voltage, no frequency
// RULE11 - code 14: constant speed running
// RULE12 - code 16: waiting for external run command
// RULE13 - code 17: output follows fault mask
// RULE14 - mask bits: undervoltage, other trips, restart
// RULE15 - code 18: fan alarm when policy zero
// RULE16 - transistor polarity: 0 open, 1 inverted
// RULE17 - relay has no polarity setting
// RULE18 - separate on/off delays, 0..10s each
// RULE19 - keypad error only after qualifying time
// RULE20 - keypad error routed by two-bit setting
// RULE21 - short pulses filtered by on/off delays
// RULE22 - delays count 0.1s ticks, load when stopped
`timescale 1ns/1ps
module docs_selector #(
  parameter int unsigned TICK_CYCLES_P = docs_pkg::TICK_CYCLES
) (
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  input  wire logic        cyc_i,
  input  wire logic        stb_i,
  input  wire logic        we_i,
  input  wire logic [5:0]  adr_i,
  input  wire logic [3:0]  sel_i,
  input  wire logic [31:0] dat_i,
  output logic      [31:0] dat_o,
  output logic             ack_o,
  input  wire logic [15:0] run_freq_i,
  input  wire logic        accel_i,
  input  wire logic        decel_i,
  input  wire logic        run_cmd_i,
  input  wire logic        volt_on_i,
  input  wire logic        wait_run_i,
  input  wire logic        trip_ov_i,
  input  wire logic        trip_uv_i,
  input  wire logic        trip_other_i,
  input  wire logic        overheat_i,
  input  wire logic        ref_lost_i,
  input  wire logic        comm_lost_i,
  input  wire logic        fan_trip_i,
  input  wire logic        restart_cfg_i,
  input  wire logic        keypad_err_i,
  output logic             transistor_output_o,
  output logic             changeover_relay_o
);
  import docs_pkg::*;

  typedef struct packed {
    logic [31:0]     rdata;
    logic            ack;
    logic [FW-1:0]   level;
    logic [FW-1:0]   band;
    logic [FW-1:0]   maxf;
    logic [4:0]      tr_sel;
    logic [4:0]      rl_sel;
    logic [2:0]      mask;
    logic            fan_policy;
    logic            polarity;
    logic [1:0]      route;
    logic [DW-1:0]   tr_on;
    logic [DW-1:0]   tr_off;
    logic [DW-1:0]   rl_on;
    logic [DW-1:0]   rl_off;
    logic [31:0]     div;
    logic            tick;
    logic            hyst;
    logic [2:0]      kp_sync;
    logic            kp_q;
    logic [7:0]      kp_cnt;
    logic            kp_err;
    logic            tr_raw;
    logic            rl_raw;
    logic            tr_out;
    logic            rl_out;
    logic [DW-1:0]   tr_cnt;
    logic [DW-1:0]   rl_cnt;
  } docs_state_type;

  docs_state_type st;
  docs_state_type next_st;

  logic [FW:0]   half_band;
  logic [FW:0]   diff;
  logic          win_match;
  logic [FW:0]   low_thr;
  logic          trip_any;
  logic          fault_hit;
  logic          bus_req;
  logic [3:0]    word;

  // frequency clamp against 400Hz and the maximum frequency setting
  function automatic logic [FW-1:0] docs_clamp(input logic [FW-1:0] v, input logic [FW-1:0] mx);
    logic [FW-1:0] lim;
    lim = (mx < FREQ_LIMIT) ? mx : FREQ_LIMIT;
    return (v > lim) ? lim : v;
  endfunction : docs_clamp

  function automatic logic [DW-1:0] docs_dclamp(input logic [DW-1:0] v);
    return (v > DELAY_LIMIT) ? DELAY_LIMIT : v;
  endfunction : docs_dclamp

  // condition chosen by a select code
  function automatic logic docs_cond(input logic [4:0] s, input logic w, input logic h, input logic f,
                                     input logic rn, input logic vo, input logic fr, input logic ac,
                                     input logic dc, input logic ov, input logic uv, input logic oh,
                                     input logic cl, input logic wr, input logic fan, input logic pol);
    logic r;
    r = 1'b0;
    case (s)
      SEL_WINDOW:    r = w;                       // RULE1
      SEL_HYST:      r = h;                       // RULE2
      SEL_HYST_INV:  r = ~h;                      // RULE3
      SEL_OVERVOLT:  r = ov;                      // RULE5
      SEL_UNDERVOLT: r = uv;                      // RULE6
      SEL_OVERHEAT:  r = oh;                      // RULE7
      SEL_CMD_LOSS:  r = cl;                      // RULE8
      SEL_RUNNING:   r = rn & vo;                 // RULE9
      SEL_STOPPED:   r = ~rn & ~vo & ~fr;         // RULE10
      SEL_CONST:     r = rn & vo & ~ac & ~dc;     // RULE11
      SEL_WAIT_RUN:  r = wr;                      // RULE12
      SEL_FAULT:     r = f;                       // RULE13
      SEL_FAN:       r = fan & ~pol;              // RULE15
      default:       r = 1'b0;
    endcase
    return r;
  endfunction : docs_cond

  assign half_band = {2'b00, st.band[FW-1:1]};
  assign diff      = (st.level > run_freq_i) ? ({1'b0, st.level} - {1'b0, run_freq_i})
                                             : ({1'b0, run_freq_i} - {1'b0, st.level});
  assign win_match = diff <= half_band;                                            // RULE1
  assign low_thr   = ({1'b0, st.level} > half_band) ? ({1'b0, st.level} - half_band) : '0;
  assign trip_any  = trip_ov_i | trip_uv_i | trip_other_i | overheat_i;
  // RULE14
  assign fault_hit = (st.mask[MASK_UV_BIT] & trip_uv_i)
                   | (st.mask[MASK_OTHER_BIT] & (trip_any & ~trip_uv_i))
                   | (st.mask[MASK_RETRY_BIT] & restart_cfg_i & trip_any);
  assign bus_req   = cyc_i & stb_i & ~st.ack;
  assign word      = adr_i[5:2];

  always_comb begin
    next_st = st;
    next_st.ack = bus_req;
    // divider giving the 0.1 s tick
    next_st.tick = 1'b0;
    if (st.div >= TICK_CYCLES_P - 1) begin
      next_st.div  = '0;
      next_st.tick = 1'b1;                                                         // RULE22
    end else begin
      next_st.div = st.div + 32'h1;
    end
    // hysteresis: set at level; below it, any frequency above the lower threshold holds it unless accelerating
    if (run_freq_i >= st.level) begin
      next_st.hyst = 1'b1;                                                         // RULE2
    end else if (accel_i || {1'b0, run_freq_i} <= low_thr) begin
      next_st.hyst = 1'b0;                                                         // RULE2
    end
    // keypad error needs to persist a qualifying number of ticks
    next_st.kp_sync = {st.kp_sync[1:0], keypad_err_i};
    if (st.kp_sync[2] == st.kp_sync[1]) begin
      next_st.kp_q = st.kp_sync[2];
    end
    if (!st.kp_q) begin
      next_st.kp_cnt = '0;
      next_st.kp_err = 1'b0;
    end else if (st.tick) begin
      if (st.kp_cnt >= 8'(KP_ERR_TICKS - 1)) begin
        next_st.kp_err = 1'b1;                                                     // RULE19
      end else begin
        next_st.kp_cnt = st.kp_cnt + 8'h1;
      end
    end
    next_st.tr_raw = docs_cond(st.tr_sel, win_match, st.hyst, fault_hit, run_cmd_i, volt_on_i,
                               run_freq_i != '0, accel_i, decel_i, trip_ov_i, trip_uv_i, overheat_i,
                               ref_lost_i | comm_lost_i, wait_run_i, fan_trip_i, st.fan_policy)
                   | (st.route[ROUTE_TR_BIT] & st.kp_err);                         // RULE20
    next_st.rl_raw = docs_cond(st.rl_sel, win_match, st.hyst, fault_hit, run_cmd_i, volt_on_i,
                               run_freq_i != '0, accel_i, decel_i, trip_ov_i, trip_uv_i, overheat_i,
                               ref_lost_i | comm_lost_i, wait_run_i, fan_trip_i, st.fan_policy)
                   | (st.route[ROUTE_RL_BIT] & st.kp_err);                         // RULE20
    // delay filters: counter restarts whenever raw agrees with the output
    if (st.tr_raw == st.tr_out) begin
      next_st.tr_cnt = '0;
    end else if ((st.tr_raw ? st.tr_on : st.tr_off) <= st.tr_cnt) begin
      next_st.tr_out = st.tr_raw;                                                  // RULE21
      next_st.tr_cnt = '0;
    end else if (st.tick) begin
      next_st.tr_cnt = st.tr_cnt + 7'h1;                                           // RULE18
    end
    if (st.rl_raw == st.rl_out) begin
      next_st.rl_cnt = '0;
    end else if ((st.rl_raw ? st.rl_on : st.rl_off) <= st.rl_cnt) begin
      next_st.rl_out = st.rl_raw;                                                  // RULE21
      next_st.rl_cnt = '0;
    end else if (st.tick) begin
      next_st.rl_cnt = st.rl_cnt + 7'h1;                                           // RULE18
    end
    // register writes; byte enables are honoured per whole register for simplicity
    if (bus_req && we_i && sel_i != 4'h0) begin
      if (word == ADR_LEVEL) begin
        next_st.level = docs_clamp(dat_i[FW-1:0], st.maxf);                       // RULE4
      end else if (word == ADR_BAND) begin
        next_st.band = docs_clamp(dat_i[FW-1:0], st.maxf);                        // RULE4
      end else if (word == ADR_MAXF) begin
        next_st.maxf  = dat_i[FW-1:0];
        next_st.level = docs_clamp(st.level, dat_i[FW-1:0]);                      // RULE4
        next_st.band  = docs_clamp(st.band, dat_i[FW-1:0]);                       // RULE4
      end else if (word == ADR_SELECT) begin
        next_st.tr_sel = dat_i[4:0];
        next_st.rl_sel = dat_i[12:8];
      end else if (word == ADR_FAULT_CFG) begin
        next_st.mask       = dat_i[2:0];
        next_st.fan_policy = dat_i[8];
        next_st.polarity   = dat_i[16];                                            // RULE16
        next_st.route      = dat_i[25:24];
      end else if (word == ADR_TR_DELAY && !run_cmd_i) begin
        next_st.tr_on  = docs_dclamp(dat_i[DW-1:0]);                               // RULE22
        next_st.tr_off = docs_dclamp(dat_i[DW+15:16]);
      end else if (word == ADR_RL_DELAY && !run_cmd_i) begin
        next_st.rl_on  = docs_dclamp(dat_i[DW-1:0]);                               // RULE22
        next_st.rl_off = docs_dclamp(dat_i[DW+15:16]);
      end
    end
    next_st.rdata = '0;
    if (word == ADR_LEVEL) begin
      next_st.rdata = {16'h0, st.level};
    end else if (word == ADR_BAND) begin
      next_st.rdata = {16'h0, st.band};
    end else if (word == ADR_MAXF) begin
      next_st.rdata = {16'h0, st.maxf};
    end else if (word == ADR_SELECT) begin
      next_st.rdata = {19'h0, st.rl_sel, 3'h0, st.tr_sel};
    end else if (word == ADR_FAULT_CFG) begin
      next_st.rdata = {6'h0, st.route, 7'h0, st.polarity, 7'h0, st.fan_policy, 5'h0, st.mask};
    end else if (word == ADR_TR_DELAY) begin
      next_st.rdata = {9'h0, st.tr_off, 9'h0, st.tr_on};
    end else if (word == ADR_RL_DELAY) begin
      next_st.rdata = {9'h0, st.rl_off, 9'h0, st.rl_on};
    end else if (word == ADR_STATUS) begin
      next_st.rdata = {26'h0, st.kp_err, st.hyst, st.rl_raw, st.tr_raw, st.rl_out, st.tr_out};
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      st            <= '0;
      st.level      <= LEVEL_RESET;                                                // RULE4
      st.band       <= BAND_RESET;
      st.maxf       <= MAXF_RESET;
      st.tr_sel     <= TR_SEL_RESET;
      st.rl_sel     <= RL_SEL_RESET;
      st.mask       <= MASK_RESET;
      st.tr_on      <= DELAY_RESET;
      st.tr_off     <= DELAY_RESET;
      st.rl_on      <= DELAY_RESET;
      st.rl_off     <= DELAY_RESET;
    end else begin
      st <= next_st;
    end
  end

  assign dat_o               = st.rdata;
  assign ack_o               = st.ack;
  assign transistor_output_o = st.tr_out ^ st.polarity;                            // RULE16
  // both contact sets exist on the relay, so its drive is never inverted
  assign changeover_relay_o  = st.rl_out;                                          // RULE17

  a_ack_one_cycle: assert property (@(posedge clk_i) disable iff (rst_i) ack_o |=> !ack_o) // RULE22
    else $error("ack held longer than one cycle");
  a_tr_polarity: assert property (@(posedge clk_i) disable iff (rst_i)
    transistor_output_o == (st.tr_out ^ st.polarity)) // RULE16
    else $error("transistor polarity wrong");
  a_window_match: assert property (@(posedge clk_i) disable iff (rst_i)
    (st.rl_sel == SEL_WINDOW && !st.route[ROUTE_RL_BIT]) |=>
      st.rl_raw == $past(win_match)) // RULE1
    else $error("window match not reflected");
  a_hyst_set: assert property (@(posedge clk_i) disable iff (rst_i)
    run_freq_i >= st.level |=> st.hyst) // RULE2
    else $error("hysteresis did not set");
  a_hyst_inv: assert property (@(posedge clk_i) disable iff (rst_i)
    (st.tr_sel == SEL_HYST_INV && st.route == 2'h0) |=> st.tr_raw == !$past(st.hyst)) // RULE3
    else $error("inverse detect wrong");
  a_level_range: assert property (@(posedge clk_i) disable iff (rst_i)
    st.level <= FREQ_LIMIT && st.band <= FREQ_LIMIT) // RULE4
    else $error("level or bandwidth out of range");
  a_zero_delay: assert property (@(posedge clk_i) disable iff (rst_i)
    (st.rl_on == '0 && st.rl_raw && !st.rl_out) |=> st.rl_out) // RULE21
    else $error("relay not following raw with zero delay");
  a_kp_qualify: assert property (@(posedge clk_i) disable iff (rst_i)
    $rose(st.kp_err) |-> st.kp_q && st.kp_cnt == 8'(KP_ERR_TICKS - 1)) // RULE19
    else $error("keypad error raised too early");
  a_delay_range: assert property (@(posedge clk_i) disable iff (rst_i)
    st.tr_on <= DELAY_LIMIT && st.rl_off <= DELAY_LIMIT) // RULE18
    else $error("delay setting out of range");

  // bus answer and hysteresis
  a_ack_after_req: assert property (@(posedge clk_i) disable iff (rst_i) // RULE4
    (cyc_i && stb_i && !ack_o) |=> ack_o)
    else $error("request not acknowledged");
  a_hyst_clear: assert property (@(posedge clk_i) disable iff (rst_i) // RULE2
    (run_freq_i < st.level && (accel_i || {1'b0, run_freq_i} <= low_thr)) |=> !st.hyst)
    else $error("hysteresis did not clear");
  a_hyst_hold: assert property (@(posedge clk_i) disable iff (rst_i) // RULE2
    (st.hyst && !accel_i && {1'b0, run_freq_i} > low_thr) |=> st.hyst)
    else $error("hysteresis dropped too early");

  // event and state selections
  a_overvolt_sel: assert property (@(posedge clk_i) disable iff (rst_i) // RULE5
    (st.tr_sel == SEL_OVERVOLT && !st.route[ROUTE_TR_BIT]) |=> st.tr_raw == $past(trip_ov_i))
    else $error("overvoltage selection wrong");
  a_undervolt_sel: assert property (@(posedge clk_i) disable iff (rst_i) // RULE6
    (st.rl_sel == SEL_UNDERVOLT && !st.route[ROUTE_RL_BIT]) |=> st.rl_raw == $past(trip_uv_i))
    else $error("undervoltage selection wrong");
  a_overheat_sel: assert property (@(posedge clk_i) disable iff (rst_i) // RULE7
    (st.rl_sel == SEL_OVERHEAT && !st.route[ROUTE_RL_BIT]) |=> st.rl_raw == $past(overheat_i))
    else $error("overheat selection wrong");
  a_cmd_loss_sel: assert property (@(posedge clk_i) disable iff (rst_i) // RULE8
    (st.rl_sel == SEL_CMD_LOSS && !st.route[ROUTE_RL_BIT]) |=>
      st.rl_raw == $past(ref_lost_i | comm_lost_i))
    else $error("command loss selection wrong");
  a_running_sel: assert property (@(posedge clk_i) disable iff (rst_i) // RULE9
    (st.tr_sel == SEL_RUNNING && !st.route[ROUTE_TR_BIT]) |=> st.tr_raw == $past(run_cmd_i & volt_on_i))
    else $error("running selection wrong");
  a_stopped_sel: assert property (@(posedge clk_i) disable iff (rst_i) // RULE10
    (st.tr_sel == SEL_STOPPED && !st.route[ROUTE_TR_BIT]) |=>
      st.tr_raw == $past(!run_cmd_i && !volt_on_i && run_freq_i == '0))
    else $error("stopped selection wrong");
  a_const_sel: assert property (@(posedge clk_i) disable iff (rst_i) // RULE11
    (st.rl_sel == SEL_CONST && !st.route[ROUTE_RL_BIT]) |=>
      st.rl_raw == $past(run_cmd_i && volt_on_i && !accel_i && !decel_i))
    else $error("constant speed selection wrong");
  a_wait_run_sel: assert property (@(posedge clk_i) disable iff (rst_i) // RULE12
    (st.rl_sel == SEL_WAIT_RUN && !st.route[ROUTE_RL_BIT]) |=> st.rl_raw == $past(wait_run_i))
    else $error("wait for run selection wrong");
  a_fault_sel: assert property (@(posedge clk_i) disable iff (rst_i) // RULE13
    (st.rl_sel == SEL_FAULT && !st.route[ROUTE_RL_BIT]) |=> st.rl_raw == $past(fault_hit))
    else $error("fault selection wrong");
  a_mask_example: assert property (@(posedge clk_i) disable iff (rst_i) // RULE13
    (st.mask == 3'h2 && trip_uv_i && !trip_ov_i && !trip_other_i && !overheat_i) |-> !fault_hit)
    else $error("undervoltage alone must not fault with mask two");
  a_mask_uv_bit: assert property (@(posedge clk_i) disable iff (rst_i) // RULE14
    (st.mask[MASK_UV_BIT] && trip_uv_i) |-> fault_hit)
    else $error("undervoltage mask bit ignored");
  a_fan_sel: assert property (@(posedge clk_i) disable iff (rst_i) // RULE15
    (st.rl_sel == SEL_FAN && !st.route[ROUTE_RL_BIT]) |=>
      st.rl_raw == $past(fan_trip_i && !st.fan_policy))
    else $error("fan alarm selection wrong");

  // keypad error and delay filters
  a_kp_clear: assert property (@(posedge clk_i) disable iff (rst_i) // RULE19
    !st.kp_q |=> !st.kp_err)
    else $error("keypad error outlived its input");
  a_kp_route: assert property (@(posedge clk_i) disable iff (rst_i) // RULE20
    (st.kp_err && st.route[ROUTE_TR_BIT]) |=> st.tr_raw)
    else $error("keypad error not routed");
  a_delay_hold: assert property (@(posedge clk_i) disable iff (rst_i) // RULE21
    (st.tr_raw != st.tr_out && (st.tr_raw ? st.tr_on : st.tr_off) > st.tr_cnt) |=>
      st.tr_out == $past(st.tr_out))
    else $error("transistor output changed before its delay");
  a_delay_lock: assert property (@(posedge clk_i) disable iff (rst_i) // RULE22
    run_cmd_i |=> $stable(st.tr_on) && $stable(st.rl_off))
    else $error("delay setting changed while running");
  a_tick_pulse: assert property (@(posedge clk_i) disable iff (rst_i) // RULE22
    st.tick |=> !st.tick)
    else $error("tick longer than one cycle");
endmodule : docs_selector

// ==== design/docs_pkg.sv ====
// constants for the drive output condition selector
package docs_pkg;
  localparam int unsigned CLK_HZ          = 250000000;
  localparam int unsigned TICK_MS         = 100;
  localparam int unsigned TICK_CYCLES     = CLK_HZ / 1000 * TICK_MS;
  localparam int          FW              = 16;
  localparam logic [15:0] FREQ_LIMIT      = 16'h9C40;
  localparam logic [15:0] LEVEL_RESET     = 16'h0BB8;
  localparam logic [15:0] BAND_RESET      = 16'h03E8;
  localparam logic [15:0] MAXF_RESET      = 16'h1770;
  localparam int          DW              = 7;
  localparam logic [6:0]  DELAY_LIMIT     = 7'h64;
  localparam logic [6:0]  DELAY_RESET     = 7'h00;
  localparam int unsigned KP_ERR_TICKS    = 30;
  localparam logic [4:0]  SEL_WINDOW      = 5'h02;
  localparam logic [4:0]  SEL_HYST        = 5'h03;
  localparam logic [4:0]  SEL_HYST_INV    = 5'h04;
  localparam logic [4:0]  SEL_OVERVOLT    = 5'h08;
  localparam logic [4:0]  SEL_UNDERVOLT   = 5'h09;
  localparam logic [4:0]  SEL_OVERHEAT    = 5'h0A;
  localparam logic [4:0]  SEL_CMD_LOSS    = 5'h0B;
  localparam logic [4:0]  SEL_RUNNING     = 5'h0C;
  localparam logic [4:0]  SEL_STOPPED     = 5'h0D;
  localparam logic [4:0]  SEL_CONST       = 5'h0E;
  localparam logic [4:0]  SEL_WAIT_RUN    = 5'h10;
  localparam logic [4:0]  SEL_FAULT       = 5'h11;
  localparam logic [4:0]  SEL_FAN         = 5'h12;
  localparam logic [4:0]  TR_SEL_RESET    = 5'h0C;
  localparam logic [4:0]  RL_SEL_RESET    = 5'h11;
  localparam logic [2:0]  MASK_RESET      = 3'h2;
  localparam int          MASK_UV_BIT     = 0;
  localparam int          MASK_OTHER_BIT  = 1;
  localparam int          MASK_RETRY_BIT  = 2;
  localparam int          ROUTE_TR_BIT    = 0;
  localparam int          ROUTE_RL_BIT    = 1;
  localparam logic [3:0]  ADR_LEVEL       = 4'h0;
  localparam logic [3:0]  ADR_BAND        = 4'h1;
  localparam logic [3:0]  ADR_MAXF        = 4'h2;
  localparam logic [3:0]  ADR_SELECT      = 4'h3;
  localparam logic [3:0]  ADR_FAULT_CFG   = 4'h4;
  localparam logic [3:0]  ADR_TR_DELAY    = 4'h5;
  localparam logic [3:0]  ADR_RL_DELAY    = 4'h6;
  localparam logic [3:0]  ADR_STATUS      = 4'h7;
endpackage : docs_pkg

// ==== verification/docs_core_model.sv ====
// drive core status model that feeds the output condition selector
`timescale 1ns/1ps
module docs_core_model (
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  input  wire logic        run_i,
  input  wire logic [15:0] target_i,
  output logic      [15:0] run_freq_o,
  output logic             accel_o,
  output logic             decel_o,
  output logic             run_cmd_o,
  output logic             volt_on_o,
  output logic             wait_run_o
);
  // ramps 1.00 Hz a clock so every threshold is crossed step by step; targets are multiples of 100
  logic [15:0] goal;
  assign goal       = run_i ? target_i : 16'h0000;
  assign accel_o    = run_freq_o < goal;
  assign decel_o    = run_freq_o > goal;
  assign run_cmd_o  = run_i;
  assign volt_on_o  = run_freq_o != 16'h0000;
  assign wait_run_o = !run_i;
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      run_freq_o <= 16'h0000;
    end else if (accel_o) begin
      run_freq_o <= run_freq_o + 16'h0064;
    end else if (decel_o) begin
      run_freq_o <= run_freq_o - 16'h0064;
    end
  end
endmodule : docs_core_model

// ==== verification/docs_selector_bench.sv ====
// self-checking bench for the drive output condition selector
`timescale 1ns/1ps
module docs_selector_bench;
  import docs_pkg::*;
  logic        clk;
  logic        rst;
  logic        cyc;
  logic        stb;
  logic        we;
  logic [5:0]  adr;
  logic [3:0]  sel;
  logic [31:0] dat;
  logic [31:0] rdat;
  logic        ack;
  logic        run;
  logic [15:0] target;
  logic [15:0] freq;
  logic        accel;
  logic        decel;
  logic        runc;
  logic        volt;
  logic        waitr;
  logic [8:0]  ev;
  logic        tr_out;
  logic        rl_out;
  int          checks;
  int          n_errors;
  logic [4:0]  tcode [5] = '{SEL_OVERVOLT, SEL_UNDERVOLT, SEL_OVERHEAT, SEL_CMD_LOSS, SEL_CMD_LOSS};
  int          tbit  [5] = '{0, 1, 3, 4, 5};
  logic [4:0]  fcode [8] = '{5'h11, 5'h11, 5'h11, 5'h11, 5'h11, 5'h11, 5'h12, 5'h12};
  logic [15:0] fcfg  [8] = '{16'h0002, 16'h0002, 16'h0001, 16'h0001, 16'h0004, 16'h0004, 16'h0000, 16'h0100};
  logic [8:0]  fev   [8] = '{9'h004, 9'h002, 9'h002, 9'h004, 9'h082, 9'h002, 9'h040, 9'h040};
  logic        fexp  [8] = '{1'b1, 1'b0, 1'b1, 1'b0, 1'b1, 1'b0, 1'b1, 1'b0};
  docs_core_model core (.clk_i(clk), .rst_i(rst), .run_i(run), .target_i(target), .run_freq_o(freq),
    .accel_o(accel), .decel_o(decel), .run_cmd_o(runc), .volt_on_o(volt), .wait_run_o(waitr));
  docs_selector #(.TICK_CYCLES_P(10)) DUT (.clk_i(clk), .rst_i(rst), .cyc_i(cyc), .stb_i(stb), .we_i(we),
    .adr_i(adr), .sel_i(sel), .dat_i(dat), .dat_o(rdat), .ack_o(ack), .run_freq_i(freq), .accel_i(accel),
    .decel_i(decel), .run_cmd_i(runc), .volt_on_i(volt), .wait_run_i(waitr), .trip_ov_i(ev[0]),
    .trip_uv_i(ev[1]), .trip_other_i(ev[2]), .overheat_i(ev[3]), .ref_lost_i(ev[4]), .comm_lost_i(ev[5]),
    .fan_trip_i(ev[6]), .restart_cfg_i(ev[7]), .keypad_err_i(ev[8]), .transistor_output_o(tr_out),
    .changeover_relay_o(rl_out));
  task automatic wrap_up();
    $display("checks %0d mismatches %0d", checks, n_errors);
    if (n_errors == 0 && checks > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : wrap_up
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      n_errors++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  // classic single cycle: hold everything until ack is sampled high, then release for one idle cycle
  task automatic wb_cycle(input logic [3:0] w, input logic wr, input logic [31:0] d, output logic [31:0] q);
    int n;
    n = 0;
    cyc <= 1'b1;
    stb <= 1'b1;
    we  <= wr;
    adr <= {w, 2'b00};
    sel <= 4'hF;
    dat <= d;
    do begin
      @(posedge clk);
      n++;
    end while (ack !== 1'b1 && n < 20);
    q = rdat;
    if (n >= 20) begin
      n_errors++;
      wrap_up();
    end
    cyc <= 1'b0;
    stb <= 1'b0;
    @(posedge clk);
  endtask : wb_cycle
  task automatic wr(input logic [3:0] w, input logic [31:0] d);
    logic [31:0] q;
    wb_cycle(w, 1'b1, d, q);
  endtask : wr
  task automatic rd(input logic [3:0] w, input logic [31:0] exp);
    logic [31:0] q;
    wb_cycle(w, 1'b0, 32'h00000000, q);
    chk(q, exp);
  endtask : rd
  // inputs reach the outputs in two to three cycles; waits leave margin over that
  task automatic outs(input int n, input logic t, input logic r);
    repeat (n) @(posedge clk);
    chk({30'h0, tr_out, rl_out}, {30'h0, t, r});
  endtask : outs
  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end
  initial begin
    {rst, cyc, stb, we, adr, sel, dat, run, target, ev, checks, n_errors} = '0;
    rst = 1'b1;
    repeat (4) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    rd(ADR_LEVEL, 32'h00000BB8);
    rd(ADR_BAND, 32'h000003E8);
    rd(ADR_MAXF, 32'h00001770);
    rd(ADR_SELECT, 32'h0000110C);
    rd(ADR_FAULT_CFG, 32'h00000002);
    rd(ADR_TR_DELAY, 32'h00000000);
    rd(ADR_RL_DELAY, 32'h00000000);
    wr(4'h9, 32'hFFFFFFFF);
    rd(4'h9, 32'h00000000);
    wr(ADR_LEVEL, 32'h0000FFFF);
    rd(ADR_LEVEL, 32'h00001770);
    wr(ADR_MAXF, 32'h0000FFFF);
    wr(ADR_LEVEL, 32'h0000FFFF);
    rd(ADR_LEVEL, 32'h00009C40);
    wr(ADR_MAXF, 32'h00001770);
    rd(ADR_LEVEL, 32'h00001770);
    wr(ADR_LEVEL, 32'h00000BB8);
    $display("test registers done");
    wr(ADR_SELECT, 32'h00000203);
    run    <= 1'b1;
    target <= 16'h0DAC;
    outs(60, 1'b1, 1'b1);
    target <= 16'h0A28;
    outs(60, 1'b1, 1'b1);
    target <= 16'h0960;
    outs(60, 1'b0, 1'b0);
    wr(ADR_SELECT, 32'h00000404);
    outs(8, 1'b1, 1'b1);
    $display("test frequency done");
    wr(ADR_SELECT, 32'h00000E0C);
    target <= 16'h03E8;
    outs(30, 1'b1, 1'b1);
    wr(ADR_SELECT, 32'h0000100D);
    outs(8, 1'b0, 1'b0);
    run <= 1'b0;
    outs(30, 1'b1, 1'b1);
    $display("test run state done");
    for (int i = 0; i < 5; i++) begin
      wr(ADR_SELECT, {19'h0, tcode[i], 3'h0, tcode[i]});
      outs(8, 1'b0, 1'b0);
      ev[tbit[i]] <= 1'b1;
      outs(8, 1'b1, 1'b1);
      ev <= '0;
    end
    $display("test trips done");
    for (int i = 0; i < 8; i++) begin
      wr(ADR_SELECT, {19'h0, fcode[i], 3'h0, fcode[i]});
      wr(ADR_FAULT_CFG, {16'h0, fcfg[i]});
      ev <= fev[i];
      outs(8, fexp[i], fexp[i]);
      ev <= '0;
    end
    $display("test fault mask done");
    wr(ADR_SELECT, 32'h00000808);
    wr(ADR_FAULT_CFG, 32'h00010000);
    outs(8, 1'b1, 1'b0);
    ev <= 9'h001;
    outs(8, 1'b0, 1'b1);
    ev <= '0;
    wr(ADR_FAULT_CFG, 32'h00000000);
    $display("test polarity done");
    // three ticks on, two ticks off; pulses below that must be swallowed
    wr(ADR_TR_DELAY, 32'h00020003);
    rd(ADR_TR_DELAY, 32'h00020003);
    ev <= 9'h001;
    outs(15, 1'b0, 1'b1);
    ev <= '0;
    outs(40, 1'b0, 1'b0);
    ev <= 9'h001;
    outs(15, 1'b0, 1'b1);
    outs(30, 1'b1, 1'b1);
    ev <= '0;
    outs(8, 1'b1, 1'b0);
    ev <= 9'h001;
    outs(40, 1'b1, 1'b1);
    run <= 1'b1;
    wr(ADR_TR_DELAY, 32'h00000000);
    rd(ADR_TR_DELAY, 32'h00020003);
    run <= 1'b0;
    wr(ADR_TR_DELAY, 32'h00000000);
    ev <= '0;
    outs(40, 1'b0, 1'b0);
    $display("test delays done");
    wr(ADR_SELECT, 32'h00000000);
    wr(ADR_FAULT_CFG, 32'h03000000);
    ev <= 9'h100;
    outs(250, 1'b0, 1'b0);
    outs(100, 1'b1, 1'b1);
    for (int r = 0; r < 4; r++) begin
      wr(ADR_FAULT_CFG, {6'h0, r[1:0], 24'h0});
      outs(8, r[0], r[1]);
    end
    rd(ADR_STATUS, 32'h0000002F);
    $display("test keypad done");
    wrap_up();
  end
endmodule : docs_selector_bench
